// >>> bench/lucp_chk_asserts.sv
`timescale 1ns/1ps
// Port relations of the LIN config block
module lucp_chk
    import lucp_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       s_axi_bvalid,
    input wire logic       rx_ident_valid,
    input wire logic [7:0] rx_ident,
    input wire logic [3:0] op_mode,
    input wire logic [3:0] tx_preamble_len,
    input wire logic       preamble_on,
    input wire logic [8:0] resp_len_bytes,
    input wire logic       sync_run,
    input wire logic       checksum_send,
    input wire logic       checksum_check,
    input wire logic       parity_send,
    input wire logic       parity_check,
    input wire logic       resp_transmit,
    input wire logic       resp_receive,
    input wire logic       wake_pulse,
    input wire logic [7:0] ident_char,
    input wire logic       guard_on
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_preamble_flag: assert property (preamble_on == (tx_preamble_len != 4'h0))
        else $error("preamble flag wrong");
    chk_sync_role: assert property (sync_run |-> op_mode == LUCP_MODE_SLAVE)
        else $error("sync runs outside slave mode");
    chk_len_range: assert property (resp_len_bytes != 9'h000 && resp_len_bytes <= 9'h100)
        else $error("response length out of range");
    chk_cksum_roles: assert property (checksum_send |-> op_mode == LUCP_MODE_MASTER
        && !checksum_check)
        else $error("checksum roles wrong");
    chk_parity_roles: assert property (parity_send |-> parity_check)
        else $error("parity sent but not checked");
    chk_action_excl: assert property (!(resp_transmit && resp_receive))
        else $error("response both sent and received");
    chk_ident_capture: assert property (rx_ident_valid && op_mode == LUCP_MODE_SLAVE
        |=> ident_char == $past(rx_ident))
        else $error("identifier not captured");
    chk_ident_hold: assert property (op_mode == LUCP_MODE_SLAVE && !rx_ident_valid
        |=> $stable(ident_char))
        else $error("identifier changed unprompted");
    chk_wake_single: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse too long");
    chk_guard_cause: assert property ($changed(guard_on) |-> $rose(s_axi_bvalid))
        else $error("guard changed without write");
endmodule

bind lucp_top lucp_chk u_chk (.*);

// >>> bench/lucp_far.sv
`timescale 1ns/1ps
// Far side: frame engine results and the DMA channel
module lucp_far (
    input  wire logic   clk,
    output logic        dma_wr,
    output logic [31:0] dma_wdata,
    output logic        rx_ident_valid,
    output logic [7:0]  rx_ident,
    output logic        sync_done,
    output logic [15:0] sync_divider_in,
    output logic [2:0]  sync_frac_in
);
    // Idle data shows the inverse so stale values never pass as fresh
    initial begin
        {dma_wr, rx_ident_valid, sync_done} = 3'h0;
        {dma_wdata, rx_ident, sync_divider_in, sync_frac_in} = '1;
    end

    // One-cycle DMA write of the LIN mode register
    task automatic dma_write(input logic [31:0] v);
        @(posedge clk);
        {dma_wr, dma_wdata} <= {1'b1, v};
        @(posedge clk);
        {dma_wr, dma_wdata} <= {1'b0, ~v};
    endtask

    // Identifier seen on the wire by a slave
    task automatic send_ident(input logic [7:0] v);
        @(posedge clk);
        {rx_ident_valid, rx_ident} <= {1'b1, v};
        @(posedge clk);
        {rx_ident_valid, rx_ident} <= {1'b0, ~v};
    endtask

    // Completed sync result
    task automatic send_sync(input logic [15:0] cd, input logic [2:0] fp);
        @(posedge clk);
        {sync_done, sync_divider_in, sync_frac_in} <= {1'b1, cd, fp};
        @(posedge clk);
        {sync_done, sync_divider_in, sync_frac_in} <= {1'b0, ~cd, ~fp};
    endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
// Bench for the LIN config and write guard block
module tb_top
    import lucp_pkg::*;
;
    localparam logic [31:0] REV = 32'h0000_0A5A; // Arbitrary value
    logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, dma_wr, rx_ident_valid, sync_done, preamble_on, sync_run;
    logic        slot_mode_on, enhanced_checksum, checksum_send, checksum_check, parity_send;
    logic        parity_check, resp_transmit, resp_receive, wake_pulse, wake_lin13, guard_on;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_ident, ident_char;
    logic [31:0] s_axi_wdata, s_axi_rdata, dma_wdata, rd_v, old_v;
    logic [3:0]  s_axi_wstrb, op_mode, tx_preamble_len;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
    logic [15:0] sync_divider_in;
    logic [2:0]  sync_frac_in;
    logic [8:0]  resp_len_bytes;
    int          bad_count, samples_checked, wakes;
    int          lens[4] = '{2, 2, 4, 8};
    int          pls[3] = '{0, 1, 15};
    logic [7:0]  prot[7] = '{LUCP_OFF_MODE, LUCP_OFF_BAUD, LUCP_OFF_RXTO, LUCP_OFF_TXTG,
                             LUCP_OFF_RATIO, LUCP_OFF_IRFLT, LUCP_OFF_MANCH};

    lucp_top #(.REVISION_CODE(REV)) u_dut (.*);
    lucp_far u_far (.*);

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Count one-cycle wake pulses
    always @(posedge clk) if (wake_pulse === 1'b1) wakes <= wakes + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Bounded cycle, a hang ends the run
    task automatic step(inout int n);
        @(posedge clk);
        n++;
        if (n > 100) begin
            bad_count++;
            $display("timeout at %0t", $time);
            results();
        end
    endtask

    // Readies seen at the falling edge, release after the rising one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int   n = 0;
        logic aw_p, w_p, b_p;
        {aw_p, w_p, b_p} = 3'b111;
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (b_p) begin
            @(negedge clk);
            b_p  = aw_p || w_p || !s_axi_bvalid;
            aw_p = aw_p && !s_axi_awready;
            w_p  = w_p && !s_axi_wready;
            step(n);
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw_p, w_p, b_p};
        end
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a);
        int   n = 0;
        logic ar_p, r_p;
        {ar_p, r_p} = 2'b11;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        while (r_p) begin
            @(negedge clk);
            r_p  = ar_p || !s_axi_rvalid;
            ar_p = ar_p && !s_axi_arready;
            if (!r_p) {rd_v, rd_r} = {s_axi_rdata, s_axi_rresp};
            step(n);
            {s_axi_arvalid, s_axi_rready} <= {ar_p, r_p};
        end
        @(posedge clk);
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (prot[i]) begin rd(prot[i]); chk(rd_v, i == 4 ? LUCP_RST_RATIO
            : i == 6 ? LUCP_RST_MANCH : 32'h0); end
        rd(LUCP_OFF_LIN_MODE); chk(rd_v, 32'h0);
        wr(LUCP_OFF_REVISION, 32'hFFFF_FFFF);
        rd(LUCP_OFF_REVISION); chk(rd_v, REV);
        rd(8'h30); chk({rd_v[29:0], rd_r}, {30'h0, LUCP_RESP_SLVERR});
        $display("test reset_and_map done");
        wr(LUCP_OFF_MODE, 32'hA);
        foreach (pls[i]) begin wr(LUCP_OFF_MANCH, 32'h3001_1000 | pls[i]); @(negedge clk);
            chk(32'({preamble_on, tx_preamble_len}), 32'({pls[i] != 0, 4'(pls[i])})); end
        for (int i = 0; i < 4; i++) begin wr(LUCP_OFF_LIN_MODE, 32'h0700 | i); @(negedge clk);
            chk(32'({resp_transmit, resp_receive, resp_len_bytes}), 32'({i == 0, i == 1, 9'd8}));
        end
        wr(LUCP_OFF_LIN_MODE, 32'h0000_FF00); @(negedge clk);
        chk(32'({checksum_send, checksum_check, parity_send, parity_check, enhanced_checksum,
            slot_mode_on, resp_len_bytes}), 32'({6'b101111, 9'h100}));
        wr(LUCP_OFF_LIN_MODE, 32'h0000_005C); @(negedge clk);
        chk(32'({checksum_send, parity_send, parity_check, enhanced_checksum, slot_mode_on}),
            32'h0);
        for (int i = 0; i < 4; i++) begin wr(LUCP_OFF_LIN_MODE, 32'h20); wr(LUCP_OFF_LIN_IDENT,
            i << 4); @(negedge clk); chk(32'(resp_len_bytes), 32'(lens[i])); end
        $display("test master_config done");
        wr(LUCP_OFF_LIN_MODE, 32'h80); wr(LUCP_OFF_LIN_CMD, 32'h1); @(negedge clk);
        chk(32'({wake_lin13, 8'(wakes)}), 32'h101);
        wr(LUCP_OFF_LIN_MODE, 32'h0); wr(LUCP_OFF_LIN_CMD, 32'h1); @(negedge clk);
        chk(32'({wake_lin13, 8'(wakes)}), 32'h002);
        $display("test wake done");
        wr(LUCP_OFF_MODE, 32'hB); @(negedge clk); chk(32'(sync_run), 32'h1);
        wr(LUCP_OFF_LIN_MODE, 32'h0002_0000); @(negedge clk); chk(32'(sync_run), 32'h0);
        u_far.send_ident(8'h3C); wr(LUCP_OFF_LIN_IDENT, 32'h55);
        rd(LUCP_OFF_LIN_IDENT); chk(rd_v, 32'h3C);
        u_far.send_sync(16'hBEEF, 3'h5); rd(LUCP_OFF_LIN_RATE); chk(rd_v, 32'h0005_BEEF);
        u_far.send_sync(16'h0001, 3'h7); rd(LUCP_OFF_LIN_RATE); chk(rd_v, 32'h0007_0001);
        wr(LUCP_OFF_LIN_MODE, 32'h0001_0000); u_far.dma_write(32'h0002_1234);
        rd(LUCP_OFF_LIN_MODE); chk(rd_v, 32'h0003_1234);
        wr(LUCP_OFF_LIN_MODE, 32'h0); u_far.dma_write(32'h0001_00FF);
        rd(LUCP_OFF_LIN_MODE); chk(rd_v, 32'h0);
        $display("test slave_and_dma done");
        wr(LUCP_OFF_GUARD_CFG, 32'h1234_5601); @(negedge clk); chk(32'(guard_on), 32'h0);
        wr(LUCP_OFF_GUARD_CFG, {LUCP_GUARD_KEY, 8'h01});
        rd(LUCP_OFF_GUARD_CFG); chk({rd_v[31:1], guard_on}, 32'h1);
        foreach (prot[i]) begin
            rd(prot[i]); old_v = rd_v; wr(prot[i], ~old_v); rd(prot[i]); chk(rd_v, old_v);
            rd(LUCP_OFF_GUARD_STS); chk(rd_v, {8'h0, 8'h0, prot[i], 8'h01});
            rd(LUCP_OFF_GUARD_STS); chk(rd_v, 32'h0);
        end
        wr(LUCP_OFF_GUARD_CFG, 32'h0); @(negedge clk); chk(32'(guard_on), 32'h1);
        wr(LUCP_OFF_GUARD_CFG, {LUCP_GUARD_KEY, 8'h00}); @(negedge clk);
        chk(32'(guard_on), 32'h0);
        wr(LUCP_OFF_BAUD, 32'h123); rd(LUCP_OFF_BAUD); chk(rd_v, 32'h123);
        rd(LUCP_OFF_GUARD_STS); chk(rd_v, 32'h0);
        $display("test write_guard done");
        results();
    end
endmodule

// >>> verilog/lucp_pkg.sv
package lucp_pkg;
    // Byte offsets of the block's registers
    localparam logic [7:0] LUCP_OFF_MODE      = 8'h00;
    localparam logic [7:0] LUCP_OFF_BAUD      = 8'h20;
    localparam logic [7:0] LUCP_OFF_RXTO      = 8'h24;
    localparam logic [7:0] LUCP_OFF_TXTG      = 8'h28;
    localparam logic [7:0] LUCP_OFF_RATIO     = 8'h40;
    localparam logic [7:0] LUCP_OFF_IRFLT     = 8'h4C;
    localparam logic [7:0] LUCP_OFF_MANCH     = 8'h50;
    localparam logic [7:0] LUCP_OFF_LIN_MODE  = 8'h54;
    localparam logic [7:0] LUCP_OFF_LIN_IDENT = 8'h58;
    localparam logic [7:0] LUCP_OFF_LIN_RATE  = 8'h5C;
    localparam logic [7:0] LUCP_OFF_LIN_CMD   = 8'h60;
    localparam logic [7:0] LUCP_OFF_GUARD_CFG = 8'hE4;
    localparam logic [7:0] LUCP_OFF_GUARD_STS = 8'hE8;
    localparam logic [7:0] LUCP_OFF_REVISION  = 8'hFC;

    // Mode register values for the LIN roles
    localparam logic [3:0] LUCP_MODE_MASTER = 4'hA;
    localparam logic [3:0] LUCP_MODE_SLAVE  = 4'hB;

    // Field positions in the LIN mode register, plus the LIN rate and MANCH registers
    localparam int LUCP_POS_NODE_ACT   = 0;
    localparam int LUCP_POS_PAR_OFF    = 2;
    localparam int LUCP_POS_CHK_OFF    = 3;
    localparam int LUCP_POS_CHK_KIND   = 4;
    localparam int LUCP_POS_LEN_SRC    = 5;
    localparam int LUCP_POS_SLOT_OFF   = 6;
    localparam int LUCP_POS_WAKE_KIND  = 7;
    localparam int LUCP_POS_LEN_FIELD  = 8;
    localparam int LUCP_POS_DMA_WRITES = 16;
    localparam int LUCP_POS_SYNC_OFF   = 17;
    localparam int LUCP_POS_FRAC       = 16;
    localparam int LUCP_POS_TXPL       = 0;

    // Reset values
    localparam logic [31:0] LUCP_RST_LIN_MODE = 32'h0000_0000;
    localparam logic [31:0] LUCP_RST_RATIO    = 32'h0000_0174;
    localparam logic [31:0] LUCP_RST_MANCH    = 32'h3001_1004;
    localparam logic [31:0] LUCP_RST_ZERO     = 32'h0000_0000;

    // Guard key and writable masks of the guarded registers and the LIN mode register
    localparam logic [23:0] LUCP_GUARD_KEY    = 24'h555341;
    localparam logic [31:0] LUCP_MASK_MODE    = 32'hFFFF_FFFF;
    localparam logic [31:0] LUCP_MASK_BAUD    = 32'h0007_FFFF;
    localparam logic [31:0] LUCP_MASK_RXTO    = 32'h0001_FFFF;
    localparam logic [31:0] LUCP_MASK_TXTG    = 32'h0000_00FF;
    localparam logic [31:0] LUCP_MASK_RATIO   = 32'h0000_07FF;
    localparam logic [31:0] LUCP_MASK_IRFLT   = 32'h0000_00FF;
    localparam logic [31:0] LUCP_MASK_MANCH   = 32'h5303_130F;
    localparam logic [31:0] LUCP_MASK_LINMODE = 32'h0003_FFFF;

    // Response handling encodings
    typedef enum logic [1:0] {
        LUCP_ACT_PUBLISH   = 2'h0,
        LUCP_ACT_SUBSCRIBE = 2'h1,
        LUCP_ACT_IGNORE    = 2'h2,
        LUCP_ACT_RESERVED  = 2'h3
    } lucp_act_t;

    // AXI response codes
    localparam logic [1:0] LUCP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LUCP_RESP_SLVERR = 2'h2;
endpackage

// >>> verilog/lucp_top.sv
`timescale 1ns/1ps
// What this block does
// (R1) Preamble length zero none, else N bits
// (R2) Slave syncs unless sync-off bit set
// (R3) DMA writes LIN mode except its select
// (R4) Length mode zero: length field plus one
// (R5) Length mode one: identifier bits 5:4
// (R6) Wake request picks 2.0 or 1.3 signal
// (R7) Slot mode runs unless slot-off bit set
// (R8) Checksum kind: enhanced or classic
// (R9) Checksum off stops send and check
// (R10) Parity off stops send and check
// (R11) Node action: publish, subscribe, ignore, reserved
// (R12) Identifier writable as master, captured as slave
// (R13) Sync divider and fraction read back
// (R14) Guard enable changes only with right key
// (R15) Right key with one on, zero off
// (R16) Guard covers seven configuration registers
// (R17) Violation flag sticks until status read
// (R18) Violation source holds offending offset
// (R19) Status read clears flag and source
// (R20) Guarded writes ignored while guard on
// (R21) Sync result updated on each completion
// (R22) Revision register fixed and read-only
module lucp_top
    import lucp_pkg::*;
#(
    parameter logic [31:0] REVISION_CODE = 32'h0000_0101 // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        dma_wr,
    input  wire logic [31:0] dma_wdata,
    input  wire logic        rx_ident_valid,
    input  wire logic [7:0]  rx_ident,
    input  wire logic        sync_done,
    input  wire logic [15:0] sync_divider_in,
    input  wire logic [2:0]  sync_frac_in,
    output logic [3:0]       op_mode,
    output logic [3:0]       tx_preamble_len,
    output logic             preamble_on,
    output logic [8:0]       resp_len_bytes,
    output logic             sync_run,
    output logic             slot_mode_on,
    output logic             enhanced_checksum,
    output logic             checksum_send,
    output logic             checksum_check,
    output logic             parity_send,
    output logic             parity_check,
    output logic             resp_transmit,
    output logic             resp_receive,
    output logic             wake_pulse,
    output logic             wake_lin13,
    output logic [7:0]       ident_char,
    output logic             guard_on
);

    // Applies byte strobes to an old word
    function automatic logic [31:0] lucp_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Register storage
    logic [31:0] mode_r, baud_r, rxto_r, txtg_r, ratio_r, irflt_r, manch_r;
    logic [31:0] lin_mode_r;
    logic [7:0]  ident_r;
    logic [15:0] sync_div_r;
    logic [2:0]  sync_frac_r;
    logic        guard_on_r;
    logic        viol_r;
    logic [15:0] viol_src_r;
    logic        wake_r;
    logic        bvalid_r, rvalid_r;
    logic [1:0]  bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic [7:0]  awaddr_r;
    logic        aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        w_held_r;

    // Write channel capture: address and data taken in either order
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    wire         aw_take   = s_axi_awvalid && s_axi_awready;
    wire         w_take    = s_axi_wvalid && s_axi_wready;
    wire         aw_have   = aw_held_r || aw_take;
    wire         w_have    = w_held_r || w_take;
    wire         wr_fire   = aw_have && w_have;
    wire [7:0]   wr_addr   = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire [31:0]  wr_data   = w_held_r ? wdata_r : s_axi_wdata;
    wire [3:0]   wr_strb   = w_held_r ? wstrb_r : s_axi_wstrb;

    // Write decode
    wire sel_mode   = wr_addr == LUCP_OFF_MODE;
    wire sel_baud   = wr_addr == LUCP_OFF_BAUD;
    wire sel_rxto   = wr_addr == LUCP_OFF_RXTO;
    wire sel_txtg   = wr_addr == LUCP_OFF_TXTG;
    wire sel_ratio  = wr_addr == LUCP_OFF_RATIO;
    wire sel_irflt  = wr_addr == LUCP_OFF_IRFLT;
    wire sel_manch  = wr_addr == LUCP_OFF_MANCH;
    wire sel_linm   = wr_addr == LUCP_OFF_LIN_MODE;
    wire sel_ident  = wr_addr == LUCP_OFF_LIN_IDENT;
    wire sel_cmd    = wr_addr == LUCP_OFF_LIN_CMD;
    wire sel_gcfg   = wr_addr == LUCP_OFF_GUARD_CFG;
    wire sel_known  = sel_mode | sel_baud | sel_rxto | sel_txtg | sel_ratio | sel_irflt
                    | sel_manch | sel_linm | sel_ident | sel_cmd | sel_gcfg
                    | (wr_addr == LUCP_OFF_LIN_RATE) | (wr_addr == LUCP_OFF_GUARD_STS)
                    | (wr_addr == LUCP_OFF_REVISION);
    wire sel_guarded = sel_mode | sel_baud | sel_rxto | sel_txtg
                     | sel_ratio | sel_irflt | sel_manch; // R16
    wire guard_block = wr_fire && sel_guarded && guard_on_r;  // R20
    wire guard_wr    = wr_fire && !guard_on_r;                // R20
    wire gcfg_full   = wr_strb == 4'hF;
    wire key_ok      = wr_data[31:8] == LUCP_GUARD_KEY;       // R14

    // Read decode
    wire         ar_take   = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rvalid_r;
    wire         rd_sts    = ar_take && (s_axi_araddr == LUCP_OFF_GUARD_STS); // R19
    logic [31:0] rd_word;
    logic        rd_known;
    always_comb begin
        rd_known = 1'b1;
        unique case (s_axi_araddr)
            LUCP_OFF_MODE:      rd_word = mode_r;
            LUCP_OFF_BAUD:      rd_word = baud_r;
            LUCP_OFF_RXTO:      rd_word = rxto_r;
            LUCP_OFF_TXTG:      rd_word = txtg_r;
            LUCP_OFF_RATIO:     rd_word = ratio_r;
            LUCP_OFF_IRFLT:     rd_word = irflt_r;
            LUCP_OFF_MANCH:     rd_word = manch_r;
            LUCP_OFF_LIN_MODE:  rd_word = lin_mode_r;
            LUCP_OFF_LIN_IDENT: rd_word = {24'h0, ident_r};
            LUCP_OFF_LIN_RATE:  rd_word = {13'h0, sync_frac_r, sync_div_r}; // R13
            LUCP_OFF_LIN_CMD:   rd_word = LUCP_RST_ZERO;
            LUCP_OFF_GUARD_CFG: rd_word = {31'h0, guard_on_r}; // R14
            LUCP_OFF_GUARD_STS: rd_word = {8'h0, viol_src_r, 7'h0, viol_r};
            LUCP_OFF_REVISION:  rd_word = REVISION_CODE; // R22
            default: begin
                rd_word  = LUCP_RST_ZERO;
                rd_known = 1'b0;
            end
        endcase
    end

    // Bus handshake state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= LUCP_RST_ZERO;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= LUCP_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= sel_known ? LUCP_RESP_OKAY : LUCP_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_r <= 1'b1;
                    awaddr_r  <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_r <= 1'b1;
                    wdata_r  <= s_axi_wdata;
                    wstrb_r  <= s_axi_wstrb;
                end
                if (s_axi_bready) begin
                    bvalid_r <= 1'b0;
                end
            end
        end
    end

    // Read answer, one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= LUCP_RST_ZERO;
            rresp_r  <= LUCP_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_known ? LUCP_RESP_OKAY : LUCP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Guarded configuration registers; a blocked write leaves them intact
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r  <= LUCP_RST_ZERO;
            baud_r  <= LUCP_RST_ZERO;
            rxto_r  <= LUCP_RST_ZERO;
            txtg_r  <= LUCP_RST_ZERO;
            ratio_r <= LUCP_RST_RATIO;
            irflt_r <= LUCP_RST_ZERO;
            manch_r <= LUCP_RST_MANCH;
        end else if (guard_wr) begin // R20
            if (sel_mode)  mode_r  <= lucp_merge(mode_r, wr_data, wr_strb) & LUCP_MASK_MODE;
            if (sel_baud)  baud_r  <= lucp_merge(baud_r, wr_data, wr_strb) & LUCP_MASK_BAUD;
            if (sel_rxto)  rxto_r  <= lucp_merge(rxto_r, wr_data, wr_strb) & LUCP_MASK_RXTO;
            if (sel_txtg)  txtg_r  <= lucp_merge(txtg_r, wr_data, wr_strb) & LUCP_MASK_TXTG;
            if (sel_ratio) ratio_r <= lucp_merge(ratio_r, wr_data, wr_strb) & LUCP_MASK_RATIO;
            if (sel_irflt) irflt_r <= lucp_merge(irflt_r, wr_data, wr_strb) & LUCP_MASK_IRFLT;
            if (sel_manch) manch_r <= lucp_merge(manch_r, wr_data, wr_strb) & LUCP_MASK_MANCH;
        end
    end

    // LIN mode register: bus writes win over a DMA write in the same cycle
    wire         dma_ok     = dma_wr && lin_mode_r[LUCP_POS_DMA_WRITES]; // R3
    wire [31:0]  dma_merged = {lin_mode_r[31:17], lin_mode_r[LUCP_POS_DMA_WRITES],
                               dma_wdata[15:0]}; // R3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lin_mode_r <= LUCP_RST_LIN_MODE;
        end else if (wr_fire && sel_linm) begin
            lin_mode_r <= lucp_merge(lin_mode_r, wr_data, wr_strb) & LUCP_MASK_LINMODE;
        end else if (dma_ok) begin
            lin_mode_r <= {14'h0, dma_wdata[LUCP_POS_SYNC_OFF], dma_merged[16:0]}; // R3
        end
    end

    // Identifier: software as master, received character as slave
    wire is_master = mode_r[3:0] == LUCP_MODE_MASTER;
    wire is_slave  = mode_r[3:0] == LUCP_MODE_SLAVE;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ident_r <= 8'h00;
        end else if (is_slave && rx_ident_valid) begin
            ident_r <= rx_ident; // R12
        end else if (is_master && wr_fire && sel_ident && wr_strb[0]) begin
            ident_r <= wr_data[7:0]; // R12
        end
    end

    // Sync result holds until the next completed sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_div_r  <= 16'h0000;
            sync_frac_r <= 3'h0;
        end else if (sync_done) begin // R21
            sync_div_r  <= sync_divider_in; // R13
            sync_frac_r <= sync_frac_in;    // R13
        end
    end

    // Guard enable only moves on a keyed full-word write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_on_r <= 1'b0;
        end else if (wr_fire && sel_gcfg && gcfg_full && key_ok) begin // R14
            guard_on_r <= wr_data[0]; // R15
        end
    end

    // Violation status; a new violation wins over the clearing read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            viol_r     <= 1'b0;
            viol_src_r <= 16'h0000;
        end else if (guard_block) begin
            viol_r     <= 1'b1;            // R17
            viol_src_r <= {8'h00, wr_addr}; // R18
        end else if (rd_sts) begin
            viol_r     <= 1'b0;            // R19
            viol_src_r <= 16'h0000;        // R19
        end
    end

    // Wake request: one-cycle pulse from a self-clearing command bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= wr_fire && sel_cmd && wr_strb[0] && wr_data[0]; // R6
        end
    end

    // Fields driven to the frame engine
    wire [1:0] act_field = lin_mode_r[LUCP_POS_NODE_ACT +: 2];
    wire       len_src   = lin_mode_r[LUCP_POS_LEN_SRC];
    wire [8:0] len_reg   = {1'b0, lin_mode_r[LUCP_POS_LEN_FIELD +: 8]} + 9'd1; // R4
    // Identifier bits 5:4 give 2, 2, 4 or 8 bytes
    logic [8:0] len_id;
    always_comb begin
        unique case (ident_r[5:4]) // R5
            2'h0, 2'h1: len_id = 9'd2;
            2'h2:       len_id = 9'd4;
            2'h3:       len_id = 9'd8;
        endcase
    end

    assign op_mode           = mode_r[3:0];
    assign tx_preamble_len   = manch_r[LUCP_POS_TXPL +: 4];
    assign preamble_on       = tx_preamble_len != 4'h0;                            // R1
    assign resp_len_bytes    = len_src ? len_id : len_reg;                         // R4
    assign sync_run          = is_slave && !lin_mode_r[LUCP_POS_SYNC_OFF];        // R2
    assign slot_mode_on      = !lin_mode_r[LUCP_POS_SLOT_OFF];                     // R7
    assign enhanced_checksum = !lin_mode_r[LUCP_POS_CHK_KIND];                     // R8
    assign checksum_send     = is_master && !lin_mode_r[LUCP_POS_CHK_OFF];         // R9
    assign checksum_check    = is_slave && !lin_mode_r[LUCP_POS_CHK_OFF];          // R9
    assign parity_send       = is_master && !lin_mode_r[LUCP_POS_PAR_OFF];         // R10
    assign parity_check      = (is_master || is_slave) && !lin_mode_r[LUCP_POS_PAR_OFF]; // R10
    assign resp_transmit     = act_field == LUCP_ACT_PUBLISH;                      // R11
    assign resp_receive      = act_field == LUCP_ACT_SUBSCRIBE;                    // R11
    assign wake_pulse        = wake_r;
    assign wake_lin13        = lin_mode_r[LUCP_POS_WAKE_KIND];                     // R6
    assign ident_char        = ident_r;
    assign guard_on          = guard_on_r;

    // Bus outputs
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

endmodule
